// [rtl/ssm_mem.sv]
`timescale 1ns/1ps
module ssm_mem #(
  parameter int DEPTH = 100,
  parameter int WIDTH = 16,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  // ==========================================================
  // storage, no reset: contents are cleared by the owner
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read data registered, one cycle after the address
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end

endmodule // ssm_mem

// [rtl/ssm_pkg.sv]
package ssm_pkg;

  // ==========================================================
  // shared memory geometry
  localparam int SSM_WORDS = 100;
  localparam logic [6:0] SSM_LAST_WORD = 7'h63;
  localparam logic [6:0] SSM_XCHG_FIRST = 7'h0A;
  localparam logic [15:0] SSM_WORD_RESET = 16'h0000;

  // ==========================================================
  // setup word indices
  localparam logic [6:0] SSM_W_PROG = 7'h00;
  localparam logic [6:0] SSM_W_START = 7'h01;
  localparam logic [6:0] SSM_W_WR_FIRST = 7'h06;
  localparam logic [6:0] SSM_W_RD_FIRST = 7'h07;

  // ==========================================================
  // field positions and codes
  localparam int SSM_PROG_LSB = 0;
  localparam int SSM_FLASH_LSB = 8;
  localparam int SSM_MODE_LSB = 0;
  localparam int SSM_XLOAD_LSB = 8;
  localparam logic [7:0] SSM_CODE_ON = 8'h5A;
  localparam logic [7:0] SSM_PROG_NO2 = 8'h02;
  localparam logic [7:0] SSM_PROG_NO3 = 8'h03;
  localparam logic [7:0] SSM_PROG_NO4 = 8'h04;
  localparam logic [7:0] SSM_AREA_NONE = 8'h00;
  localparam logic [3:0] SSM_XLOAD_OFF = 4'h0;

  // ==========================================================
  // control states
  typedef enum logic [1:0] {
    SSM_CLEAR = 2'b00,
    SSM_LOAD = 2'b01,
    SSM_RUN = 2'b10
  } ssm_state_t;

  // ==========================================================
  // area membership: an area runs from its first word up to
  // the other area's first word, or to the last word
  function automatic logic ssm_in_area(input logic [6:0] idx,
                                       input logic [7:0] first,
                                       input logic [7:0] other);
    logic [7:0] i;
    logic valid;
    i = {1'b0, idx};
    valid = (first >= {1'b0, SSM_XCHG_FIRST}) &&
            (first <= {1'b0, SSM_LAST_WORD});
    ssm_in_area = valid && (i >= first) &&
                  (i <= {1'b0, SSM_LAST_WORD}) &&
                  ((other <= first) || (i < other));
  endfunction

  // startup program code to program index 0..3
  function automatic logic [1:0] ssm_prog_decode(input logic [7:0] c);
    unique case (c)
      SSM_PROG_NO2: ssm_prog_decode = 2'h1;
      SSM_PROG_NO3: ssm_prog_decode = 2'h2;
      SSM_PROG_NO4: ssm_prog_decode = 2'h3;
      default: ssm_prog_decode = 2'h0;
    endcase
  endfunction

endpackage

// [rtl/ssm_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - hundred 16-bit shared words per unit
// - words 0-9 setup, 10-99 exchange
// - no retention; power-up clears every word
// - setup words taken from host at load
// - word 0 low byte selects startup program
// - word 0 high byte 5A copies flash
// - word 1 low byte 5A auto-starts program
// - word 1 bits 11:8 enable exchange load
// - host-read area written only by put
// - host-write area read only by get
// - independent area first words, any order
// - word 6 gives host-write area first
// - word 7 gives host-read area first
module ssm_top
  import ssm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [6:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic load_done,
  output logic host_ready,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  output logic host_err,
  input wire logic put_valid,
  input wire logic [6:0] put_addr,
  input wire logic [15:0] put_data,
  output logic put_ready,
  input wire logic get_valid,
  input wire logic [6:0] get_addr,
  output logic get_ready,
  output logic [15:0] get_rdata,
  output logic get_rvalid,
  output logic cmd_err,
  input wire logic start_switch,
  input wire logic term_run,
  output logic [1:0] prog_sel,
  output logic flash_copy,
  output logic prog_start,
  output logic running,
  output logic loading,
  output logic [7:0] wr_area_first,
  output logic [7:0] rd_area_first
);

  // ==========================================================
  // state
  ssm_state_t state_reg;
  logic [6:0] clr_cnt_reg;
  logic [15:0] stage_w0_reg, stage_w1_reg, act_w0_reg, act_w1_reg;
  logic [7:0] stage_w6_reg, stage_w7_reg, act_w6_reg, act_w7_reg;
  logic host_rvalid_reg, host_err_reg, get_rvalid_reg, cmd_err_reg;
  logic flash_copy_reg, prog_start_reg, running_reg;
  logic sw_meta_reg, sw_sync_reg, sw_prev_reg;

  logic mem_we;
  logic [6:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic host_req, host_in_range, host_legal;
  logic host_wr_ok, host_rd_ok, put_acc, get_acc, put_ok, get_ok;
  logic in_rd_host, in_wr_host, xload_en;
  logic apply, auto_mode, sw_rise, manual_go;
  default clocking ssm_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // access legality
  assign host_ready = (state_reg != SSM_CLEAR);
  assign host_req = host_ready && (host_wr || host_rd);
  assign host_in_range = (host_addr <= SSM_LAST_WORD);
  assign in_rd_host = ssm_in_area(host_addr, act_w7_reg, act_w6_reg);
  assign in_wr_host = ssm_in_area(host_addr, act_w6_reg, act_w7_reg);
  assign xload_en = (stage_w1_reg[SSM_XLOAD_LSB +: 4] != SSM_XLOAD_OFF);

  always_comb begin
    host_legal = 1'b0;
    if (host_in_range) begin
      if (host_addr < SSM_XCHG_FIRST) begin
        // setup writes always stored; applied if made in load, wiped by the restart clear if made in run
        host_legal = host_wr;
      end else if (state_reg == SSM_LOAD) begin
        host_legal = host_wr && xload_en;
      end else if (host_wr) begin
        host_legal = in_wr_host;
      end else begin
        host_legal = in_rd_host;
      end
    end
  end

  assign host_wr_ok = host_req && host_wr && host_legal;
  assign host_rd_ok = host_req && !host_wr && host_legal;

  // device commands yield to the host so no host access is lost
  assign put_ready = (state_reg == SSM_RUN) && !host_req;
  assign get_ready = (state_reg == SSM_RUN) && !host_req && !put_valid;
  assign put_acc = put_valid && put_ready;
  assign get_acc = get_valid && get_ready;
  assign put_ok = put_acc &&
                  ssm_in_area(put_addr, act_w7_reg, act_w6_reg);
  assign get_ok = get_acc &&
                  ssm_in_area(get_addr, act_w6_reg, act_w7_reg);

  // ==========================================================
  // memory port mux
  always_comb begin
    mem_we = 1'b0;
    mem_addr = clr_cnt_reg;
    mem_wdata = SSM_WORD_RESET;
    if (state_reg == SSM_CLEAR) begin
      mem_we = 1'b1;
    end else if (host_req) begin
      mem_addr = host_addr;
      mem_we = host_wr_ok;
      mem_wdata = host_wdata;
    end else if (put_acc) begin
      mem_addr = put_addr;
      mem_we = put_ok;
      mem_wdata = put_data;
    end else if (get_acc) begin
      mem_addr = get_addr;
    end
  end

  ssm_mem #(
    .DEPTH(SSM_WORDS),
    .WIDTH(16),
    .AW(7)
  ) u_mem (
    .clk(mclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // control sequence: clear, load, run
  assign apply = (state_reg == SSM_LOAD) && load_done && !restart;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SSM_CLEAR;
      clr_cnt_reg <= 7'h00;
    end else if (restart) begin
      state_reg <= SSM_CLEAR;
      clr_cnt_reg <= 7'h00;
    end else begin
      unique case (state_reg)
        SSM_CLEAR: begin
          clr_cnt_reg <= clr_cnt_reg + 7'h01;
          if (clr_cnt_reg == SSM_LAST_WORD) begin
            state_reg <= SSM_LOAD;
          end
        end
        SSM_LOAD: begin
          if (load_done) begin
            state_reg <= SSM_RUN;
          end
        end
        SSM_RUN: state_reg <= SSM_RUN;
        default: state_reg <= SSM_CLEAR;
      endcase
    end
  end

  // ==========================================================
  // setup staging, cleared with the memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage_w0_reg <= SSM_WORD_RESET;
      stage_w1_reg <= SSM_WORD_RESET;
      stage_w6_reg <= SSM_AREA_NONE;
      stage_w7_reg <= SSM_AREA_NONE;
    end else if (state_reg == SSM_CLEAR) begin
      stage_w0_reg <= SSM_WORD_RESET;
      stage_w1_reg <= SSM_WORD_RESET;
      stage_w6_reg <= SSM_AREA_NONE;
      stage_w7_reg <= SSM_AREA_NONE;
    end else if (host_wr_ok) begin
      if (host_addr == SSM_W_PROG) stage_w0_reg <= host_wdata;
      if (host_addr == SSM_W_START) stage_w1_reg <= host_wdata;
      if (host_addr == SSM_W_WR_FIRST) stage_w6_reg <= host_wdata[7:0];
      if (host_addr == SSM_W_RD_FIRST) stage_w7_reg <= host_wdata[7:0];
    end
  end

  // active setup changes only here; edits in run never apply, the restart clear wipes them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_w0_reg <= SSM_WORD_RESET;
      act_w1_reg <= SSM_WORD_RESET;
      act_w6_reg <= SSM_AREA_NONE;
      act_w7_reg <= SSM_AREA_NONE;
    end else if (state_reg == SSM_CLEAR) begin
      act_w0_reg <= SSM_WORD_RESET;
      act_w1_reg <= SSM_WORD_RESET;
      act_w6_reg <= SSM_AREA_NONE;
      act_w7_reg <= SSM_AREA_NONE;
    end else if (apply) begin
      act_w0_reg <= stage_w0_reg;
      act_w1_reg <= stage_w1_reg;
      act_w6_reg <= stage_w6_reg;
      act_w7_reg <= stage_w7_reg;
    end
  end

  assign prog_sel = ssm_prog_decode(act_w0_reg[SSM_PROG_LSB +: 8]);
  assign wr_area_first = act_w6_reg;
  assign rd_area_first = act_w7_reg;
  assign loading = (state_reg != SSM_RUN);
  assign auto_mode = (stage_w1_reg[SSM_MODE_LSB +: 8] == SSM_CODE_ON);

  // ==========================================================
  // start switch crosses in from the panel pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_reg <= 1'b0;
      sw_sync_reg <= 1'b0;
      sw_prev_reg <= 1'b0;
    end else begin
      sw_meta_reg <= start_switch;
      sw_sync_reg <= sw_meta_reg;
      sw_prev_reg <= sw_sync_reg;
    end
  end

  assign sw_rise = sw_sync_reg && !sw_prev_reg;
  assign manual_go = (state_reg == SSM_RUN) && !running_reg &&
                     !restart && (sw_rise || term_run);

  // ==========================================================
  // startup events
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_copy_reg <= 1'b0;
      prog_start_reg <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      flash_copy_reg <= apply &&
        (stage_w0_reg[SSM_FLASH_LSB +: 8] == SSM_CODE_ON);
      prog_start_reg <= (apply && auto_mode) || manual_go;
      if (restart) begin
        running_reg <= 1'b0;
      end else if ((apply && auto_mode) || manual_go) begin
        running_reg <= 1'b1;
      end
    end
  end

  assign flash_copy = flash_copy_reg;
  assign prog_start = prog_start_reg;
  assign running = running_reg;

  // ==========================================================
  // answers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_rvalid_reg <= 1'b0;
      host_err_reg <= 1'b0;
      get_rvalid_reg <= 1'b0;
      cmd_err_reg <= 1'b0;
    end else begin
      host_rvalid_reg <= host_rd_ok;
      host_err_reg <= host_req && !host_legal;
      get_rvalid_reg <= get_ok;
      cmd_err_reg <= (put_acc && !put_ok) || (get_acc && !get_ok);
    end
  end

  assign host_rvalid = host_rvalid_reg;
  assign host_err = host_err_reg;
  assign host_rdata = mem_rdata;
  assign get_rvalid = get_rvalid_reg;
  assign get_rdata = mem_rdata;
  assign cmd_err = cmd_err_reg;

  // ==========================================================
  // checks
  AST_CLEAR_LEN: assert property (
    $past(state_reg) == SSM_CLEAR && state_reg == SSM_LOAD
    |-> $past(clr_cnt_reg) == 7'h63)
    else $error("clear sweep not 100 words");
  AST_CLEAR_ZERO: assert property (
    state_reg == SSM_CLEAR |-> mem_we && mem_wdata == 16'h0000)
    else $error("clear did not write default");
  AST_RANGE: assert property (
    host_req && host_addr > 7'h63 |=> host_err)
    else $error("out of range host access not refused");
  AST_RD_AREA_PUT: assert property (
    state_reg == SSM_RUN && mem_we && mem_addr >= 7'h0A &&
    ssm_in_area(mem_addr, act_w7_reg, act_w6_reg) |-> put_valid && put_ready)
    else $error("host-read area written by other than put");
  AST_GET_AREA: assert property (
    get_rvalid |-> $past(get_valid) &&
    ssm_in_area($past(get_addr), act_w6_reg, act_w7_reg))
    else $error("get answered outside host-write area");
  AST_XLOAD: assert property (
    state_reg == SSM_LOAD && host_wr && host_addr >= 7'h0A &&
    stage_w1_reg[11:8] == 4'h0 |-> !mem_we ##1 host_err)
    else $error("exchange word loaded while load disabled");
  AST_HOLD: assert property (
    $past(state_reg) == SSM_RUN && state_reg == SSM_RUN
    |-> $stable(act_w1_reg) && $stable(act_w6_reg))
    else $error("active setup changed during run");
  AST_FLASH: assert property (
    apply |=> flash_copy == ($past(stage_w0_reg[15:8]) == 8'h5A))
    else $error("flash copy does not follow code");
  AST_AUTO: assert property (
    apply && stage_w1_reg[7:0] == 8'h5A |=> prog_start && running)
    else $error("auto start missing");
  AST_MANUAL: assert property (
    state_reg == SSM_RUN && !running_reg && !sw_rise && !term_run
    |=> !prog_start)
    else $error("start without trigger");
  AST_PROG: assert property (
    apply && stage_w0_reg[7:0] == 8'h04 |=> prog_sel == 2'h3)
    else $error("program 4 not selected");
  COV_AUTO: cover property (apply ##1 prog_start);
  COV_PUT: cover property (put_ok);
  COV_GET: cover property (get_ok ##1 get_rvalid);
  COV_FLASH: cover property (flash_copy);

endmodule // ssm_top

// [tb/ssm_host_model.sv]
`timescale 1ns/1ps
module ssm_host_model #(
  parameter int UNIT = 3
) (
  input wire logic mclk,
  input wire logic host_ready,
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic host_err,
  output logic host_wr,
  output logic host_rd,
  output logic [6:0] host_addr,
  output logic [15:0] host_wdata,
  output logic load_done
);
  // ==========================================================
  // host data memory block of this unit
  localparam int BASE = 1000 + 100 * UNIT;
  logic [15:0] host_data_memory [BASE:BASE+99];

  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 7'h00;
    host_wdata = 16'h0000;
    load_done = 1'b0;
    for (int i = 0; i < 100; i++) host_data_memory[BASE+i] = 16'h0000;
  end

  task automatic set_word(input int i, input logic [15:0] v);
    // unused bits of the start word kept at zero
    host_data_memory[BASE+i] = (i == 1) ? {4'h0, v[11:0]} : v;
  endtask

  // ==========================================================
  // host accesses; released lines show inverted values
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge mclk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    while (host_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d,
                    output logic e);
    d = 16'hXXXX;
    e = 1'b0;
    @(negedge mclk);
    host_rd = 1'b1;
    host_addr = a;
    while (host_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    host_rd = 1'b0;
    host_addr = ~a;
    repeat (2) begin
      if (host_rvalid === 1'b1) d = host_rdata;
      if (host_err === 1'b1) e = 1'b1;
      @(negedge mclk);
    end
  endtask

  // setup words resent after every power-up or restart, exchange words only with load enabled
  task automatic resend();
    for (int i = 0; i < 10; i++) wr(7'(i), host_data_memory[BASE+i]);
    // unloaded exchange words stay host work storage
    if (host_data_memory[BASE+1][11:8] != 4'h0) begin
      for (int i = 10; i < 100; i++) wr(7'(i), host_data_memory[BASE+i]);
    end
    @(negedge mclk);
    load_done = 1'b1;
    @(negedge mclk);
    load_done = 1'b0;
  endtask
endmodule // ssm_host_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import ssm_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic restart = 1'b0;
  logic host_wr, host_rd, load_done;
  logic [6:0] host_addr;
  logic [15:0] host_wdata;
  logic host_ready, host_rvalid, host_err;
  logic [15:0] host_rdata;
  logic put_valid = 1'b0;
  logic [6:0] put_addr = 7'h00;
  logic [15:0] put_data = 16'h0000;
  logic get_valid = 1'b0;
  logic [6:0] get_addr = 7'h00;
  logic put_ready, get_ready, get_rvalid, cmd_err;
  logic [15:0] get_rdata;
  logic start_switch = 1'b0;
  logic term_run = 1'b0;
  logic [1:0] prog_sel;
  logic flash_copy, prog_start, running, loading;
  logic [7:0] wr_area_first, rd_area_first;
  int failures = 0;
  int total_checks = 0;
  int fc_cnt = 0;
  int ps_cnt = 0;
  logic [15:0] q;
  logic e;

  always #5 mclk = ~mclk;

  ssm_top u_ssm_top (.mclk(mclk), .rst_n(rst_n), .restart(restart),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .load_done(load_done),
    .host_ready(host_ready), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_err(host_err),
    .put_valid(put_valid), .put_addr(put_addr), .put_data(put_data),
    .put_ready(put_ready), .get_valid(get_valid), .get_addr(get_addr),
    .get_ready(get_ready), .get_rdata(get_rdata),
    .get_rvalid(get_rvalid), .cmd_err(cmd_err),
    .start_switch(start_switch), .term_run(term_run),
    .prog_sel(prog_sel), .flash_copy(flash_copy),
    .prog_start(prog_start), .running(running), .loading(loading),
    .wr_area_first(wr_area_first), .rd_area_first(rd_area_first));

  ssm_host_model u_host (.mclk(mclk), .host_ready(host_ready),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .host_err(host_err), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .load_done(load_done));

  always @(posedge mclk) begin
    if (flash_copy === 1'b1) fc_cnt++;
    if (prog_start === 1'b1) ps_cnt++;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] y);
    total_checks++;
    if (y !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic unit_cmd(input logic g, input logic [6:0] a,
                          input logic [15:0] d);
    q = 16'hXXXX;
    e = 1'b0;
    @(negedge mclk);
    get_valid = g;
    put_valid = !g;
    get_addr = a;
    put_addr = a;
    put_data = d;
    while ((g ? get_ready : put_ready) !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    get_valid = 1'b0;
    put_valid = 1'b0;
    get_addr = ~a;
    put_addr = ~a;
    put_data = ~d;
    repeat (2) begin
      if (get_rvalid === 1'b1) q = get_rdata;
      if (cmd_err === 1'b1) e = 1'b1;
      @(negedge mclk);
    end
  endtask

  task automatic reload();
    @(negedge mclk);
    restart = 1'b1;
    @(negedge mclk);
    restart = 1'b0;
    u_host.resend();
    repeat (2) @(negedge mclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_clear();
    int n;
    n = 0;
    chk("loading", 16'h0001, {15'h0, loading});
    while (host_ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("clear_len", 16'h0064, 16'(n));
    $display("done t_clear");
  endtask

  task automatic t_codes();
    int f;
    u_host.set_word(7, 16'h000A);
    u_host.set_word(10, 16'hBEEF);
    for (int c = 0; c < 5; c++) begin
      f = fc_cnt;
      u_host.set_word(0, {(c == 4) ? 8'h5A : 8'h00, 8'(c)});
      reload();
      chk("prog_sel", 16'((c < 2) ? 0 : c - 1), 16'(prog_sel));
      chk("flash", 16'((c == 4) ? 1 : 0), 16'(fc_cnt - f));
      u_host.rd(7'h0A, q, e);
      chk("unloaded", 16'h0000, q);
    end
    u_host.rd(7'h00, q, e);
    chk("setup_rd_err", 16'h0001, {15'h0, e});
    u_host.rd(7'h64, q, e);
    chk("range_err", 16'h0001, {15'h0, e});
    chk("wr_none", 16'h0000, 16'(wr_area_first));
    unit_cmd(1'b1, 7'h32, 16'h0000);
    chk("get_none", 16'h0001, {15'h0, e});
    $display("done t_codes");
  endtask

  task automatic t_exchange();
    u_host.set_word(1, 16'h0100);
    u_host.set_word(6, 16'h000A);
    u_host.set_word(7, 16'h0014);
    for (int i = 10; i < 100; i++) u_host.set_word(i, 16'hA000 + 16'(i));
    reload();
    chk("wr_first", 16'h000A, 16'(wr_area_first));
    chk("rd_first", 16'h0014, 16'(rd_area_first));
    unit_cmd(1'b1, 7'h0F, 16'h0000);
    chk("get_load", 16'hA00F, q);
    unit_cmd(1'b1, 7'h19, 16'h0000);
    chk("get_err", 16'h0001, {15'h0, e});
    unit_cmd(1'b0, 7'h1E, 16'h1234);
    chk("put_ok", 16'h0000, {15'h0, e});
    u_host.rd(7'h1E, q, e);
    chk("host_rd_put", 16'h1234, q);
    unit_cmd(1'b0, 7'h0C, 16'h7777);
    chk("put_err", 16'h0001, {15'h0, e});
    u_host.rd(7'h0C, q, e);
    chk("rd_area_err", 16'h0001, {15'h0, e});
    u_host.rd(7'h63, q, e);
    chk("xload", 16'hA063, q);
    u_host.wr(7'h10, 16'h5555);
    unit_cmd(1'b1, 7'h10, 16'h0000);
    chk("get_host_wr", 16'h5555, q);
    $display("done t_exchange");
  endtask

  task automatic t_start();
    int p;
    u_host.set_word(1, 16'h0000);
    reload();
    p = ps_cnt;
    chk("manual_idle", 16'h0000, {15'h0, running});
    @(negedge mclk);
    term_run = 1'b1;
    @(negedge mclk);
    term_run = 1'b0;
    repeat (2) @(negedge mclk);
    chk("term_run", 16'h0001, 16'(ps_cnt - p));
    reload();
    start_switch = 1'b1;
    repeat (8) @(negedge mclk);
    start_switch = 1'b0;
    chk("switch_run", 16'h0001, {15'h0, running});
    u_host.set_word(1, 16'h005A);
    p = ps_cnt;
    reload();
    chk("auto_start", 16'h0001, 16'(ps_cnt - p));
    // setup change while running never applies; the next restart clears it
    // active code is still program 4 from the earlier load
    u_host.wr(7'h00, 16'h0002);
    repeat (3) @(negedge mclk);
    chk("late_setup", 16'h0003, 16'(prog_sel));
    $display("done t_start");
  endtask

  // ==========================================================
  // run control
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("BAD watchdog expected done seen hang");
    close_out();
  end

  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    t_clear();
    t_codes();
    t_exchange();
    t_start();
    close_out();
  end
endmodule // testbench
